// file: hdl/hsli_regs.svh
// register offsets, field positions and reset values of the strap latch block
// assumes a 12-bit APB byte address and 32-bit data
`ifndef HSLI_REGS_SVH
`define HSLI_REGS_SVH

// register byte offsets
`define HSLI_CTRL_OFFSET      12'h000
`define HSLI_STRAP_OFFSET     12'h004
`define HSLI_OC_LEVEL_OFFSET  12'h008
`define HSLI_IRQ_STAT_OFFSET  12'h00C
`define HSLI_IRQ_MASK_OFFSET  12'h010

// control register fields
`define HSLI_CTRL_STRAP_EN    0
`define HSLI_CTRL_HIGH_SPEED  1
`define HSLI_CTRL_CONFIGURED  2
`define HSLI_CTRL_SUSPENDED   3
`define HSLI_CTRL_PORT1_ON    4
`define HSLI_CTRL_PORT2_ON    5
`define HSLI_CTRL_WIDTH       6
`define HSLI_CTRL_RESET       6'h01

// strap status register fields
`define HSLI_STRAP_SEL_LSB    0
`define HSLI_STRAP_FIXED_LSB  4
`define HSLI_STRAP_BOOST_LSB  6
`define HSLI_STRAP_PORTS_LSB  9
`define HSLI_STRAP_HELD       16

// interrupt registers, one bit per downstream port 7..1
`define HSLI_IRQ_MASK_RESET   7'h00

`endif

// file: hdl/hsli_pkg.sv
// types and shared helpers of the strap latch block
// assumes nothing beyond a SystemVerilog compiler
package hsli_pkg;

	// capture state of the strap latch
	typedef enum logic [0:0] {
		HSLI_WAIT_RELEASE = 1'b0,
		HSLI_HOLD         = 1'b1
	} hsli_latch_state_type;

	// two-bit fixed-port strap code
	typedef logic [1:0] hsli_code_type;

	// fixed-port code to a port-3..1 mask, bit 0 is port 1
	function automatic logic [2:0] hsli_fixed_ports(input hsli_code_type code);
		case (code)
			2'h0:    return 3'h0;
			2'h1:    return 3'h1;
			2'h2:    return 3'h3;
			default: return 3'h7;
		endcase
	endfunction

	// level on a pin for a logical state and a polarity
	function automatic logic hsli_drive(input logic active, input logic active_low);
		return active ^ active_low;
	endfunction

	// merge write data into an old word under byte strobes
	function automatic logic [31:0] hsli_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] strb);
		logic [31:0] result;
		result = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				result[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return result;
	endfunction

endpackage

// file: hdl/hsli_strap_if.sv
// bundle between the strap latch and the indicator top level
// assumes the latch and the top level share one clock
`timescale 1ns/1ps
`default_nettype none
interface hsli_strap_if;
	logic       select_0_pin;
	logic       select_1_pin;
	logic       select_2_pin;
	logic       strap_hi_pin;
	logic       strap_lo_pin;
	logic [1:0] boost_pins;
	logic       held;
	logic [2:0] config_select;
	logic [1:0] fixed_code;
	logic [1:0] boost_code;

	modport latch (
		input  select_0_pin, select_1_pin, select_2_pin,
		input  strap_hi_pin, strap_lo_pin, boost_pins,
		output held, config_select, fixed_code, boost_code
	);
	modport user (
		output select_0_pin, select_1_pin, select_2_pin,
		output strap_hi_pin, strap_lo_pin, boost_pins,
		input  held, config_select, fixed_code, boost_code
	);
endinterface
`default_nettype wire

// file: hdl/hsli_strap_latch.sv
// strap latch: takes all strap pins once after reset release and holds them
// assumes pins synchronous to clk and stable across the release
`timescale 1ns/1ps
`default_nettype none
module hsli_strap_latch #(
	parameter bit HAS_SELECT_2_PIN = 1'b1
) (
	// clock and reset
	input  wire logic     clk,
	input  wire logic     reset,
	// strap bundle
	hsli_strap_if.latch   straps
);
	import hsli_pkg::*;

	hsli_latch_state_type state;

	// one capture on the first edge after release, then hold until reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state                 <= HSLI_WAIT_RELEASE;
			straps.config_select  <= 3'h0;
			straps.fixed_code     <= 2'h0;
			straps.boost_code     <= 2'h0;
		end else begin
			case (state)
				HSLI_WAIT_RELEASE: begin
					straps.config_select[0] <= straps.select_0_pin;
					straps.config_select[1] <= straps.select_1_pin;
					straps.config_select[2] <= HAS_SELECT_2_PIN
						? straps.select_2_pin : 1'b0;
					straps.fixed_code       <= {straps.strap_hi_pin,
						straps.strap_lo_pin};
					straps.boost_code       <= straps.boost_pins;
					state                   <= HSLI_HOLD;
				end
				HSLI_HOLD: begin
					state <= HSLI_HOLD;
				end
				default: begin
					state <= HSLI_WAIT_RELEASE;
				end
			endcase
		end
	end

	// latched values are valid from here on
	assign straps.held = (state == HSLI_HOLD);
endmodule // hsli_strap_latch
`default_nettype wire

// file: hdl/hsli_top.sv
// hub strap latch and indicators: straps, polarities, indicators, over-current
// assumes an APB master on clk and synchronous pin inputs
// board holds the straps across reset release
//
// Notes on behaviour
// - with drive-boost strap 11 both enhanced port indicators are active low.
// - each of ports 7..1 has an active-low over-current sense input, low reports a fault.
// - with the strap function enabled both fixed-port strap bits classify ports 3..1.
// - fixed-port code 00 none fixed, 01 port 1, 10 ports 1-2, 11 ports 1-3.
// - select bit 0 is caught from the serial clock pin at reset release.
// - select bit 1 is caught from the speed indicator pin at reset release.
// - the speed indicator is active high for select bit 1 at 0, active low at 1.
// - the speed indicator is asserted at high speed and negated at full speed.
// - select bit 2 reads 0 without its pin, else it is caught like the others.
// - the suspend indicator is active low for code 01 with the strap function enabled, else active high.
// - the suspend indicator is asserted only while configured and not suspended.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hsli_regs.svh"
module hsli_top #(
	parameter bit HAS_SELECT_2_PIN = 1'b1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// apb slave
	input  wire logic [11:0]      paddr,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	// interrupt
	output logic                  irq,
	// strap-only inputs
	input  wire logic             mgmt_serial_clock,
	input  wire logic             mgmt_serial_data,
	input  wire logic             config_method_select_2,
	// speed indicator pin, shared with select bit 1
	input  wire logic             config_method_select_1,
	output logic                  upstream_speed_indicator,
	output logic                  speed_pin_oe_n,
	// suspend indicator pin, shared with the low fixed-port strap
	input  wire logic             fixed_port_strap_lo,
	output logic                  suspend_indicator,
	output logic                  suspend_pin_oe_n,
	// enhanced port indicator pins, shared with the drive-boost strap
	input  wire logic [1:0]       drive_boost_strap,
	output logic                  port1_enhanced_indicator,
	output logic                  port2_enhanced_indicator,
	output logic                  port_pins_oe_n,
	// over-current sense
	input  wire logic [7:1]       overcurrent_sense_n,
	// to the hub core
	output logic [2:0]            config_method,
	output logic [3:1]            fixed_ports
);
	import hsli_pkg::*;

	// ************************************************************
	// strap latch
	// ************************************************************

	// pins in, held straps out
	hsli_strap_if straps ();

	// route shared pins into the latch bundle
	assign straps.select_0_pin = mgmt_serial_clock;
	assign straps.select_1_pin = config_method_select_1;
	assign straps.select_2_pin = config_method_select_2;
	assign straps.strap_hi_pin = mgmt_serial_data;
	assign straps.strap_lo_pin = fixed_port_strap_lo;
	assign straps.boost_pins   = drive_boost_strap;

	hsli_strap_latch #(
		.HAS_SELECT_2_PIN (HAS_SELECT_2_PIN)
	) u_latch (
		.clk    (clk),
		.reset  (reset),
		.straps (straps)
	);

	// ************************************************************
	// register storage
	// ************************************************************

	logic [`HSLI_CTRL_WIDTH-1:0] ctrl;
	logic [7:1]                  irq_status;
	logic [7:1]                  irq_mask;
	logic [7:1]                  oc_active;
	logic [7:1]                  oc_seen;
	logic [7:1]                  oc_rise;
	logic [7:1]                  irq_clear;
	logic [7:1]                  next_irq_status;
	logic [31:0]                 next_prdata;
	logic [31:0]                 strap_word;
	logic [31:0]                 ctrl_word;
	logic [31:0]                 mask_word;
	logic                        setup_phase;
	logic                        access_done;
	logic                        write_done;
	logic                        read_done;
	logic                        addr_mapped;
	logic                        next_slverr;
	logic [31:0]                 ctrl_merged;
	logic [31:0]                 mask_merged;
	logic [7:1]                  stat_returned;

	// ************************************************************
	// apb decode
	// ************************************************************

	// setup and completed access of a transfer
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign write_done  = access_done & pwrite;
	assign read_done   = access_done & ~pwrite;

	// zero-wait slave, every access ends in its first access cycle
	assign pready = 1'b1;

	// word views of the control and mask registers
	assign ctrl_word = {{(32-`HSLI_CTRL_WIDTH){1'b0}}, ctrl};
	assign mask_word = {24'h000000, irq_mask, 1'b0};

	// known offsets
	always_comb begin
		case (paddr)
			`HSLI_CTRL_OFFSET:     addr_mapped = 1'b1;
			`HSLI_STRAP_OFFSET:    addr_mapped = 1'b1;
			`HSLI_OC_LEVEL_OFFSET: addr_mapped = 1'b1;
			`HSLI_IRQ_STAT_OFFSET: addr_mapped = 1'b1;
			`HSLI_IRQ_MASK_OFFSET: addr_mapped = 1'b1;
			default:               addr_mapped = 1'b0;
		endcase
	end

	// ************************************************************
	// control register
	// ************************************************************

	// merged write word
	assign ctrl_merged = hsli_merge(ctrl_word, pwdata, pstrb);

	// software sets strap use, link state and port indicator requests
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl <= `HSLI_CTRL_RESET;
		end else if (write_done && paddr == `HSLI_CTRL_OFFSET) begin
			ctrl <= ctrl_merged[`HSLI_CTRL_WIDTH-1:0];
		end
	end

	// ************************************************************
	// interrupt mask register
	// ************************************************************

	// merged write word
	assign mask_merged = hsli_merge(mask_word, pwdata, pstrb);

	// one mask bit per port, set bit lets the event through
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_mask <= `HSLI_IRQ_MASK_RESET;
		end else if (write_done && paddr == `HSLI_IRQ_MASK_OFFSET) begin
			irq_mask <= mask_merged[7:1];
		end
	end

	// ************************************************************
	// over-current sense
	// ************************************************************

	// low sense level means an over-current report
	assign oc_active = ~overcurrent_sense_n;

	// previous level for the onset detector
	// idle level after reset, no false onset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			oc_seen <= 7'h00;
		end else begin
			oc_seen <= oc_active;
		end
	end

	// one event per new report
	assign oc_rise = oc_active & ~oc_seen;

	// ************************************************************
	// interrupt status
	// ************************************************************

	// bits returned by the finishing read
	assign stat_returned = prdata[7:1];

	// a read of the status register clears what it returned
	// so an event on the setup edge survives
	assign irq_clear = (read_done && paddr == `HSLI_IRQ_STAT_OFFSET)
		? stat_returned : 7'h00;

	// a new event in the clearing cycle survives
	assign next_irq_status = (irq_status & ~irq_clear) | oc_rise;

	// sticky event bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_status <= 7'h00;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// level interrupt while any unmasked event is pending
	// next status, so irq rises with its bit
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// ************************************************************
	// read path
	// ************************************************************

	// strap status word
	always_comb begin
		strap_word = 32'h00000000;
		strap_word[`HSLI_STRAP_SEL_LSB +: 3]   = straps.config_select;
		strap_word[`HSLI_STRAP_FIXED_LSB +: 2] = straps.fixed_code;
		strap_word[`HSLI_STRAP_BOOST_LSB +: 2] = straps.boost_code;
		strap_word[`HSLI_STRAP_PORTS_LSB +: 3] = fixed_ports;
		strap_word[`HSLI_STRAP_HELD]           = straps.held;
	end

	// read data chosen in the setup cycle
	always_comb begin
		case (paddr)
			`HSLI_CTRL_OFFSET:     next_prdata = ctrl_word;
			`HSLI_STRAP_OFFSET:    next_prdata = strap_word;
			`HSLI_OC_LEVEL_OFFSET: next_prdata = {24'h000000, oc_active, 1'b0};
			`HSLI_IRQ_STAT_OFFSET: next_prdata = {24'h000000, irq_status, 1'b0};
			`HSLI_IRQ_MASK_OFFSET: next_prdata = mask_word;
			default:               next_prdata = 32'h00000000;
		endcase
		next_slverr = ~addr_mapped;
	end

	// read data and error stand through the access cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata  <= pwrite ? 32'h00000000 : next_prdata;
			pslverr <= next_slverr;
		end
	end

	// ************************************************************
	// strap outputs to the hub core
	// ************************************************************

	// effective fixed-port code, ignored when strap use is off
	hsli_code_type fixed_code_use;
	assign fixed_code_use = ctrl[`HSLI_CTRL_STRAP_EN] ? straps.fixed_code : 2'h0;

	// selection bits and fixed-port classification
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			config_method <= 3'h0;
			fixed_ports   <= 3'h0;
		end else begin
			config_method <= straps.config_select;
			fixed_ports   <= hsli_fixed_ports(fixed_code_use);
		end
	end

	// ************************************************************
	// indicator polarity
	// ************************************************************

	logic speed_low;
	logic suspend_low;
	logic port1_low;
	logic port2_low;

	// polarities follow the held straps
	assign speed_low   = straps.config_select[1];
	assign suspend_low = (fixed_code_use == 2'h1);
	assign port1_low   = straps.boost_code[0];
	assign port2_low   = straps.boost_code[1];

	// ************************************************************
	// indicator drive
	// ************************************************************

	logic speed_on;
	logic suspend_on;

	// logical indicator states
	assign speed_on   = ctrl[`HSLI_CTRL_HIGH_SPEED];
	assign suspend_on = ctrl[`HSLI_CTRL_CONFIGURED]
		& ~ctrl[`HSLI_CTRL_SUSPENDED];

	// pin levels, released until the straps are held
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			upstream_speed_indicator <= 1'b0;
			suspend_indicator        <= 1'b0;
			port1_enhanced_indicator <= 1'b0;
			port2_enhanced_indicator <= 1'b0;
		end else begin
			upstream_speed_indicator <= hsli_drive(speed_on, speed_low);
			suspend_indicator        <= hsli_drive(suspend_on, suspend_low);
			port1_enhanced_indicator <= hsli_drive(ctrl[`HSLI_CTRL_PORT1_ON],
				port1_low);
			port2_enhanced_indicator <= hsli_drive(ctrl[`HSLI_CTRL_PORT2_ON],
				port2_low);
		end
	end

	// pins stay undriven through reset and the capture edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			speed_pin_oe_n   <= 1'b1;
			suspend_pin_oe_n <= 1'b1;
			port_pins_oe_n   <= 1'b1;
		end else begin
			speed_pin_oe_n   <= ~straps.held;
			suspend_pin_oe_n <= ~straps.held;
			port_pins_oe_n   <= ~straps.held;
		end
	end

endmodule // hsli_top
`default_nettype wire

// file: test/hsli_top_sva.sv
// checker for the strap latch top level
// assumes it is bound to hsli_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module hsli_top_sva #(
	parameter bit HAS_SELECT_2_PIN = 1'b1
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        mgmt_serial_clock,
	input wire logic        mgmt_serial_data,
	input wire logic        config_method_select_2,
	input wire logic        config_method_select_1,
	input wire logic        upstream_speed_indicator,
	input wire logic        speed_pin_oe_n,
	input wire logic        fixed_port_strap_lo,
	input wire logic        suspend_indicator,
	input wire logic        suspend_pin_oe_n,
	input wire logic [1:0]  drive_boost_strap,
	input wire logic        port1_enhanced_indicator,
	input wire logic        port2_enhanced_indicator,
	input wire logic        port_pins_oe_n,
	input wire logic [7:1]  overcurrent_sense_n,
	input wire logic [2:0]  config_method,
	input wire logic [3:1]  fixed_ports
);
	// ****************
	// shadow state
	// ****************
	logic [5:0] ctrl_m;
	logic [7:1] mask_m;
	logic       arm;
	logic [2:0] sel_m;
	logic [1:0] fc_m;
	logic [1:0] bst_m;
	logic       wr;
	assign wr = psel && penable && pready && pwrite && pstrb[0];
	// control and mask copies from apb writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_m <= 6'h01;
			mask_m <= 7'h00;
		end else if (wr && paddr == 12'h000) begin
			ctrl_m <= pwdata[5:0];
		end else if (wr && paddr == 12'h010) begin
			mask_m <= pwdata[7:1];
		end
	end
	// first edge after release
	always_ff @(posedge clk or posedge reset) begin
		if (reset) arm <= 1'b1;
		else arm <= 1'b0;
	end
	// strap copy taken at that edge
	always_ff @(posedge clk) begin
		if (arm && !reset) begin
			sel_m <= {config_method_select_2 & HAS_SELECT_2_PIN, config_method_select_1,
				mgmt_serial_clock};
			fc_m <= {mgmt_serial_data, fixed_port_strap_lo};
			bst_m <= drive_boost_strap;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_CFG_HELD: assert property (!speed_pin_oe_n |-> config_method == sel_m)
		else $error("config method differs from captured straps");
	AST_FIXED: assert property (!suspend_pin_oe_n && $stable(ctrl_m) |-> fixed_ports ==
		(ctrl_m[0] ? {fc_m == 2'h3, fc_m[1], fc_m != 2'h0} : 3'h0))
		else $error("fixed port mask wrong");
	AST_SPEED: assert property (!speed_pin_oe_n && $stable(ctrl_m) |->
		upstream_speed_indicator == (ctrl_m[1] ^ sel_m[1]))
		else $error("speed indicator level wrong");
	AST_SUSP: assert property (!suspend_pin_oe_n && $stable(ctrl_m) |-> suspend_indicator ==
		((ctrl_m[2] && !ctrl_m[3]) ^ (ctrl_m[0] && fc_m == 2'h1)))
		else $error("suspend indicator level wrong");
	AST_PORT: assert property (!port_pins_oe_n && $stable(ctrl_m) |->
		{port2_enhanced_indicator, port1_enhanced_indicator} == (ctrl_m[5:4] ^ bst_m))
		else $error("port indicator level wrong");
	AST_OC_IRQ: assert property (|(mask_m & $past(overcurrent_sense_n) & ~overcurrent_sense_n)
		|=> irq)
		else $error("over-current did not raise irq");
	AST_NO_IRQ: assert property (mask_m == 7'h00 && $past(mask_m) == 7'h00 |-> !irq)
		else $error("irq with all sources masked");
	AST_READY: assert property (psel |-> pready)
		else $error("apb wait state");
	AST_BAD_ADDR: assert property (psel && penable && !(paddr inside {12'h000, 12'h004,
		12'h008, 12'h00C, 12'h010}) |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	cover property (!port_pins_oe_n && bst_m == 2'h3);
	cover property ($rose(irq));
	cover property (psel && penable && pslverr);
endmodule // hsli_top_sva
bind hsli_top hsli_top_sva #(.HAS_SELECT_2_PIN(HAS_SELECT_2_PIN)) u_sva (.clk, .reset,
	.paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq,
	.mgmt_serial_clock, .mgmt_serial_data, .config_method_select_2, .config_method_select_1,
	.upstream_speed_indicator, .speed_pin_oe_n, .fixed_port_strap_lo, .suspend_indicator,
	.suspend_pin_oe_n, .drive_boost_strap, .port1_enhanced_indicator,
	.port2_enhanced_indicator, .port_pins_oe_n, .overcurrent_sense_n, .config_method,
	.fixed_ports);
`default_nettype wire

// file: test/hsli_board_model.sv
// board model: strap resistors, shared pins and current monitors
// assumes strap holds {sel2, sel1, sel0, fixed hi, fixed lo, boost[1:0]}
`timescale 1ns/1ps
`default_nettype none
module hsli_board_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [6:0] strap,
	input  wire logic [7:1] fault,
	input  wire logic       upstream_speed_indicator,
	input  wire logic       speed_pin_oe_n,
	input  wire logic       suspend_indicator,
	input  wire logic       suspend_pin_oe_n,
	input  wire logic       port1_enhanced_indicator,
	input  wire logic       port2_enhanced_indicator,
	input  wire logic       port_pins_oe_n,
	output logic            mgmt_serial_clock,
	output logic            mgmt_serial_data,
	output logic            config_method_select_2,
	output logic            config_method_select_1,
	output logic            fixed_port_strap_lo,
	output logic [1:0]      drive_boost_strap,
	output logic [7:1]      overcurrent_sense_n
);
	logic [1:0] quiet;
	logic       tgl;
	// bus stays quiet past the capture edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			quiet <= 2'h0;
			tgl <= 1'b0;
		end else begin
			tgl <= !tgl;
			if (quiet != 2'h3) quiet <= quiet + 2'h1;
		end
	end
	// serial pins: strap level, then traffic
	assign mgmt_serial_clock = (quiet == 2'h3) ? tgl : strap[4];
	assign mgmt_serial_data = (quiet == 2'h3) ? !tgl : strap[3];
	assign config_method_select_2 = strap[6];
	// shared pins: device level when driven, else resistor
	assign config_method_select_1 = speed_pin_oe_n ? strap[5] : upstream_speed_indicator;
	assign fixed_port_strap_lo = suspend_pin_oe_n ? strap[2] : suspend_indicator;
	assign drive_boost_strap = port_pins_oe_n ? strap[1:0] :
		{port2_enhanced_indicator, port1_enhanced_indicator};
	// monitors pull low on fault
	assign overcurrent_sense_n = ~fault;
endmodule // hsli_board_model
`default_nettype wire

// file: test/test_hub_strap_latch_indicators.sv
// bench for the strap latch top level
// assumes the board model and bound checker
`timescale 1ns/1ps
`default_nettype none
module test_hub_strap_latch_indicators;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [6:0]  strap;
	logic [7:1]  fault, overcurrent_sense_n;
	logic        mgmt_serial_clock, mgmt_serial_data, config_method_select_2;
	logic        config_method_select_1, fixed_port_strap_lo;
	logic [1:0]  drive_boost_strap;
	logic        upstream_speed_indicator, speed_pin_oe_n, suspend_indicator;
	logic        suspend_pin_oe_n, port1_enhanced_indicator, port2_enhanced_indicator;
	logic        port_pins_oe_n;
	logic [2:0]  config_method;
	logic [3:1]  fixed_ports;
	int          n_errors, n_compared, cyc;
	hsli_top dut (.clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .irq, .mgmt_serial_clock, .mgmt_serial_data,
		.config_method_select_2, .config_method_select_1, .upstream_speed_indicator,
		.speed_pin_oe_n, .fixed_port_strap_lo, .suspend_indicator, .suspend_pin_oe_n,
		.drive_boost_strap, .port1_enhanced_indicator, .port2_enhanced_indicator,
		.port_pins_oe_n, .overcurrent_sense_n, .config_method, .fixed_ports);
	hsli_board_model board (.clk, .reset, .strap, .fault, .upstream_speed_indicator,
		.speed_pin_oe_n, .suspend_indicator, .suspend_pin_oe_n, .port1_enhanced_indicator,
		.port2_enhanced_indicator, .port_pins_oe_n, .mgmt_serial_clock, .mgmt_serial_data,
		.config_method_select_2, .config_method_select_1, .fixed_port_strap_lo,
		.drive_boost_strap, .overcurrent_sense_n);
	// ****************
	// tasks
	// ****************
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	task end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			end_of_test;
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// one apb transfer, no fixed wait assumed
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		chk($sformatf("read %h", a), r, exp);
		chk("pslverr", {31'h0, e}, {31'h0, err});
	endtask
	task rst(input logic [6:0] s);
		@(posedge clk);
		strap <= s;
		@(posedge clk);
		reset <= 1'b1;
		repeat (5) @(posedge clk);
		chk("oe_reset", {speed_pin_oe_n, suspend_pin_oe_n, port_pins_oe_n}, 3'h7);
		reset <= 1'b0;
		look(3);
		chk("oe_held", {speed_pin_oe_n, suspend_pin_oe_n, port_pins_oe_n}, 3'h0);
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		logic [1:0] c;
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		strap = 7'h00;
		fault = 7'h00;
		{n_errors, n_compared, cyc} = '0;
		// every fixed-port and boost code with select patterns
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			rst({1'b1, c[0], c[1], c, c});
			chk("config_method", {29'h0, config_method}, {29'h1, c[0], c[1]});
			chk("fixed_ports", {29'h0, fixed_ports}, {29'h0, c == 2'h3, c[1], c != 2'h0});
			chk("speed", upstream_speed_indicator, c[0]);
			chk("suspend", suspend_indicator, c == 2'h1);
			chk("ports", {port2_enhanced_indicator, port1_enhanced_indicator}, c);
			rd(12'h004, {15'h0, 1'b1, 4'h0, c == 2'h3, c[1], c != 2'h0, 1'b0, c, c, 1'b0,
				1'b1, c[0], c[1]}, 1'b0);
			wr(12'h000, 32'h37);
			look(1);
			chk("speed_hs", upstream_speed_indicator, !c[0]);
			chk("suspend_on", suspend_indicator, c != 2'h1);
			chk("ports_on", {port2_enhanced_indicator, port1_enhanced_indicator},
				{30'h0, ~c});
			wr(12'h000, 32'h3F);
			look(1);
			chk("suspend_sleep", suspend_indicator, c == 2'h1);
			$display("test straps %0d done", i);
		end
		wr(12'h000, 32'h3E);
		look(2);
		chk("fixed_off", {29'h0, fixed_ports}, 32'h0);
		rd(12'h000, 32'h3E, 1'b0);
		$display("test strap enable done");
		// masked and unmasked over-current
		wr(12'h010, 32'h0A);
		fault[3] <= 1'b1;
		look(2);
		chk("irq_set", irq, 1'b1);
		rd(12'h008, 32'h08, 1'b0);
		rd(12'h00C, 32'h08, 1'b0);
		look(1);
		chk("irq_clear", irq, 1'b0);
		@(posedge clk);
		fault[2] <= 1'b1;
		look(2);
		chk("irq_masked", irq, 1'b0);
		rd(12'h00C, 32'h04, 1'b0);
		rd(12'h00C, 32'h00, 1'b0);
		$display("test over-current done");
		// refused and read-only accesses
		wr(12'h008, 32'hFFFFFFFF);
		rd(12'h008, 32'h0C, 1'b0);
		rd(12'h014, 32'h0, 1'b1);
		rd(12'h010, 32'h0A, 1'b0);
		$display("test access done");
		end_of_test;
	end
endmodule // test_hub_strap_latch_indicators
`default_nettype wire
